// ### hw/vport_pkg.sv
// Purpose: shared constants and types for the video port sync and snapshot control
// Assumes: 8-bit register writes from the serial register port decoder
// Notes: bit positions are named here so the logic never holds a bare number
package vport_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] OFS_SYNC_CFG = 8'h07;
  localparam logic [7:0] OFS_LEAD_ADJ = 8'h08;
  localparam logic [7:0] OFS_SNAP_CFG = 8'h09;

  // reset values
  localparam logic [7:0] RST_SYNC_CFG = 8'h00;
  localparam logic [7:0] RST_LEAD_ADJ = 8'h00;
  localparam logic [7:0] RST_SNAP_CFG = 8'h00;

  // sync configuration register fields
  localparam int B_PCLK_GATE = 7;
  localparam int B_FS_FORM = 6;
  localparam int B_LS_FORM = 5;
  localparam int B_PCLK_EDGE = 4;
  localparam int B_FS_POL = 3;
  localparam int B_LS_POL = 2;
  localparam int B_FIELD_EN = 1;
  localparam int B_FLOAT = 0;

  // lead adjust field
  localparam int B_LEAD_HI = 7;
  localparam int B_LEAD_LO = 4;

  // snapshot configuration fields
  localparam int B_FRM_HI = 7;
  localparam int B_FRM_LO = 6;
  localparam int B_SHUTTER = 5;
  localparam int B_XSYNC_POL = 4;
  localparam int B_TRIG_FORM = 2;
  localparam int B_TRIG_EDGE = 1;
  localparam int B_TRIG_EN = 0;

  // sync pulse length in pixel clocks and link cycles per pixel clock
  localparam int SYNC_PULSE_PCLKS = 4;
  localparam int LINK_CYC_PER_PCLK = 2;
  localparam int SYNC_PULSE_CYC = SYNC_PULSE_PCLKS * LINK_CYC_PER_PCLK;
  // first valid pixel sits past the largest lead offset
  localparam int DATA_START_COL = 16;

  // port timing settings carried into the link domain
  typedef struct packed {
    logic pclk_gate;
    logic fs_form;
    logic ls_form;
    logic pclk_edge;
    logic fs_pol;
    logic ls_pol;
    logic field_en;
    logic port_float;
    logic [3:0] lead;
  } port_cfg_s;

  // snapshot sequencer states
  typedef enum logic [1:0] {
    SNAP_IDLE,
    SNAP_EXPOSE,
    SNAP_READOUT
  } snap_state_e;

endpackage : vport_pkg

// ### hw/level_sync2.sv
// Purpose: two-flop synchroniser for levels entering a clock domain
// Assumes: each bit is a slow level or a toggle; bits may skew by one cycle
// Notes: the first stage feeds the second stage only
`timescale 1ns/1ps
module level_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // metastability catch stage
  logic [WIDTH-1:0] meta_r;
  // settled stage
  logic [WIDTH-1:0] sync_r;

  // no reset: the chain flushes in two edges
  always_ff @(posedge i_clk) begin
    meta_r <= i_async;
    sync_r <= meta_r;
  end

  assign o_sync = sync_r;

endmodule : level_sync2

// ### hw/vport_sync_snap.sv
// Purpose: video port sync timing and snapshot trigger sequencing
// Assumes: i_pix_clk runs at two link cycles per pixel clock, free running
// Notes: settings cross to the link domain as slow levels; rewrite between frames
//
// Overview of operation
// R01 - gating bit: pixel clock only with data
// R02 - frame sync form bit: pulse or level
// R03 - line sync pulse four pclks at row end
// R04 - edge bit picks falling or rising active
// R05 - frame polarity in level form; pulse low
// R06 - line polarity in level form; pulse low
// R07 - field bit puts odd/even on frame pin
// R08 - float bit releases all port outputs
// R09 - lead offset moves line sync 0-15; code applies it to the level form only, the pulse form ignores it
// R10 - shutterless snapshot waits coded frame count
// R11 - software must write non-zero frame count
// R12 - shutter bit selects external shutter sequence
// R13 - external sync polarity bit inverts it
// R14 - level form repeats while trigger active
// R15 - pulse form runs one sequence per pulse
// R16 - trigger edge bit rising or falling
// R17 - trigger enable bit gates the pin
// R18 - trigger pin synchronised before detection
`timescale 1ns/1ps
module vport_sync_snap #(
  parameter int DATA_W = 12,
  parameter int ACT_COLS = 648,
  parameter int ACT_ROWS = 488,
  parameter int H_BLANK = 32,
  parameter int V_BLANK = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_pix_clk,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_snapshot_trig,
  output logic o_ext_sync,
  output logic o_snap_busy,
  input wire logic [DATA_W-1:0] i_pix_data,
  output logic [DATA_W-1:0] o_pix_data,
  output logic o_pclk,
  output logic o_line_sync,
  output logic o_frame_sync,
  output logic o_port_oe
);

  localparam int LINE_LEN = vport_pkg::DATA_START_COL + ACT_COLS + H_BLANK;
  localparam int FRAME_ROWS = ACT_ROWS + V_BLANK;
  localparam int DATA_END_COL = vport_pkg::DATA_START_COL + ACT_COLS;

  // refuse shapes the counters and pulses cannot serve
  initial begin
    if (H_BLANK < vport_pkg::SYNC_PULSE_PCLKS || V_BLANK < 1 || LINE_LEN > 4095 ||
        FRAME_ROWS > 4095 || ACT_COLS < 1 || ACT_ROWS < 1 || DATA_W < 1) begin
      $error("vport_sync_snap: unsupported geometry parameters");
    end
  end

  // ---------------- core domain: registers ----------------
  logic [7:0] sync_cfg_r; // pixel clock and sync shape settings
  logic [7:0] lead_adj_r; // line sync lead offset
  logic [7:0] snap_cfg_r; // snapshot settings
  logic [7:0] rdata_r; // registered read answer

  // register writes from the serial register port
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync_cfg_r <= vport_pkg::RST_SYNC_CFG;
      lead_adj_r <= vport_pkg::RST_LEAD_ADJ;
      snap_cfg_r <= vport_pkg::RST_SNAP_CFG;
    end else if (i_reg_wr) begin
      // frame count 00 is stored as written; software owns avoiding it
      case (i_reg_addr)
        vport_pkg::OFS_SYNC_CFG: sync_cfg_r <= i_reg_wdata;
        vport_pkg::OFS_LEAD_ADJ: lead_adj_r <= i_reg_wdata;
        vport_pkg::OFS_SNAP_CFG: snap_cfg_r <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux, unmapped offsets answer zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else begin
      case (i_reg_addr)
        vport_pkg::OFS_SYNC_CFG: rdata_r <= sync_cfg_r;
        vport_pkg::OFS_LEAD_ADJ: rdata_r <= lead_adj_r;
        vport_pkg::OFS_SNAP_CFG: rdata_r <= snap_cfg_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  assign o_reg_rdata = rdata_r;

  // field views of the snapshot register
  logic trig_en; // pin enabled
  logic trig_level; // level form
  logic trig_rise; // rising edge active
  logic shutter; // external shutter sequence
  logic [1:0] frm_need; // frames before readout
  assign trig_en = snap_cfg_r[vport_pkg::B_TRIG_EN];
  assign trig_level = snap_cfg_r[vport_pkg::B_TRIG_FORM];
  assign trig_rise = snap_cfg_r[vport_pkg::B_TRIG_EDGE];
  assign shutter = snap_cfg_r[vport_pkg::B_SHUTTER];
  assign frm_need = snap_cfg_r[vport_pkg::B_FRM_HI:vport_pkg::B_FRM_LO];

  // ---------------- core domain: trigger ----------------
  logic trig_s; // synchronised pin
  logic [1:0] tgl_s; // synchronised frame-end and output-done toggles
  logic act_prev_r; // last active-level sample
  logic fe_prev_r; // last frame-end toggle
  logic od_prev_r; // last output-done toggle
  logic fe_tgl_r;
  logic od_tgl_r;

  // R18 pin synchroniser
  level_sync2 #(.WIDTH(1)) u_trig_sync (
    .i_clk(i_core_clk),
    .i_async(i_snapshot_trig),
    .o_sync(trig_s)
  );
  level_sync2 #(.WIDTH(2)) u_tgl_sync (
    .i_clk(i_core_clk),
    .i_async({fe_tgl_r, od_tgl_r}),
    .o_sync(tgl_s)
  );

  logic trig_act; // pin at its active level
  logic trig_edge; // active edge seen
  logic frame_end; // any frame finished
  logic out_done; // a read-out frame finished
  // R16 edge select sets active level
  assign trig_act = trig_rise ? trig_s : ~trig_s;
  assign trig_edge = trig_act & ~act_prev_r;
  assign frame_end = tgl_s[1] ^ fe_prev_r;
  assign out_done = tgl_s[0] ^ od_prev_r;

  // edge and toggle history
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      act_prev_r <= 1'b1;
      fe_prev_r <= 1'b0;
      od_prev_r <= 1'b0;
    end else begin
      act_prev_r <= trig_act;
      fe_prev_r <= tgl_s[1];
      od_prev_r <= tgl_s[0];
    end
  end

  // ---------------- core domain: snapshot sequencer ----------------
  vport_pkg::snap_state_e state_r;
  logic [1:0] frm_cnt_r; // frames seen while exposing
  logic grant_r; // link domain may read frames out
  logic xsync_r; // external sync pin level
  logic busy_r;

  // sequence steps
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= vport_pkg::SNAP_IDLE;
      frm_cnt_r <= 2'b00;
    end else begin
      case (state_r)
        vport_pkg::SNAP_IDLE: begin
          frm_cnt_r <= 2'b00;
          // R17 pin ignored when disabled
          if (trig_en && (trig_level ? trig_act : trig_edge)) begin
            state_r <= vport_pkg::SNAP_EXPOSE;
          end
        end
        vport_pkg::SNAP_EXPOSE: begin
          if (frame_end) begin
            frm_cnt_r <= frm_cnt_r + 2'b01;
            // R12 shutter sequence exposes one frame
            if (shutter) begin
              state_r <= vport_pkg::SNAP_READOUT;
            // R10 wait coded frame count
            end else if (frm_cnt_r + 2'b01 == frm_need) begin
              state_r <= vport_pkg::SNAP_READOUT;
            end
          end
        end
        vport_pkg::SNAP_READOUT: begin
          frm_cnt_r <= 2'b00;
          if (out_done) begin
            // R14 level form repeats
            if (trig_en && trig_level && trig_act) begin
              state_r <= vport_pkg::SNAP_EXPOSE;
            // R15 pulse form stops after one
            end else begin
              state_r <= vport_pkg::SNAP_IDLE;
            end
          end
        end
        default: state_r <= vport_pkg::SNAP_IDLE;
      endcase
    end
  end

  // readout grant, external sync and busy flags
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      grant_r <= 1'b1;
      xsync_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      // R17 disabled pin means free video
      grant_r <= ~trig_en || (state_r == vport_pkg::SNAP_READOUT);
      // R13 external sync polarity
      xsync_r <= (state_r == vport_pkg::SNAP_EXPOSE) ^ snap_cfg_r[vport_pkg::B_XSYNC_POL];
      busy_r <= (state_r != vport_pkg::SNAP_IDLE);
    end
  end
  assign o_ext_sync = xsync_r;
  assign o_snap_busy = busy_r;

  // ---------------- link domain ----------------
  logic prst_meta_r; // reset catch
  logic prst_r; // reset in link domain
  // reset crossing, no reset on the chain itself
  always_ff @(posedge i_pix_clk) begin
    prst_meta_r <= i_rst;
    prst_r <= prst_meta_r;
  end

  vport_pkg::port_cfg_s cfg_core; // settings as held in core domain
  vport_pkg::port_cfg_s cfg_s; // synchronised settings, bits may skew
  vport_pkg::port_cfg_s cfg_prev_r; // previous synchronised sample
  vport_pkg::port_cfg_s pc; // settings seen by link logic
  logic grant_p; // grant seen by link logic
  assign cfg_core = {sync_cfg_r, lead_adj_r[vport_pkg::B_LEAD_HI:vport_pkg::B_LEAD_LO]};
  level_sync2 #(.WIDTH($bits(vport_pkg::port_cfg_s) + 1)) u_cfg_sync (
    .i_clk(i_pix_clk),
    .i_async({cfg_core, grant_r}),
    .o_sync({cfg_s, grant_p})
  );

  // word taken only when two samples agree, so a skewed mix never shapes the pins
  always_ff @(posedge i_pix_clk) begin
    cfg_prev_r <= cfg_s;
    if (cfg_s == cfg_prev_r) begin
      pc <= cfg_s;
    end
  end

  logic ph_r; // half of a pixel clock
  logic [11:0] col_r;
  logic [11:0] row_r;
  logic step; // last link cycle of a pixel
  assign step = ph_r;

  // pixel and row counters
  always_ff @(posedge i_pix_clk) begin
    if (prst_r) begin
      ph_r <= 1'b0;
      col_r <= 12'h000;
      row_r <= 12'h000;
    end else begin
      ph_r <= ~ph_r;
      if (step) begin
        if (col_r == 12'(LINE_LEN - 1)) begin
          col_r <= 12'h000;
          row_r <= (row_r == 12'(FRAME_ROWS - 1)) ? 12'h000 : row_r + 12'h001;
        end else begin
          col_r <= col_r + 12'h001;
        end
      end
    end
  end

  logic row_act; // row inside the active frame
  logic col_act; // column inside the valid data
  logic ls_lvl; // line sync level region
  logic ls_pls; // line sync pulse region
  logic fs_pls; // frame sync pulse region
  assign row_act = row_r < 12'(ACT_ROWS);
  assign col_act = (col_r >= 12'(vport_pkg::DATA_START_COL)) && (col_r < 12'(DATA_END_COL));
  // R09 lead offset starts line sync early
  assign ls_lvl = row_act && (col_r >= 12'(vport_pkg::DATA_START_COL) - 12'(pc.lead)) &&
                  (col_r < 12'(DATA_END_COL));
  // R03 four-pixel pulse after data end
  assign ls_pls = row_act && (col_r >= 12'(DATA_END_COL)) &&
                  (col_r < 12'(DATA_END_COL + vport_pkg::SYNC_PULSE_PCLKS));
  assign fs_pls = (row_r == 12'(ACT_ROWS)) && (col_r < 12'(vport_pkg::SYNC_PULSE_PCLKS));

  logic frm_out_r; // current frame is read out
  logic field_r; // odd/even field
  logic pix_on_r; // data valid on the port
  logic ls_r;
  logic fs_r;
  logic pclk_r;
  logic oe_r;
  logic [DATA_W-1:0] data_r;

  // frame start latch, field and frame-end toggles
  always_ff @(posedge i_pix_clk) begin
    if (prst_r) begin
      frm_out_r <= 1'b0;
      field_r <= 1'b0;
      fe_tgl_r <= 1'b0;
      od_tgl_r <= 1'b0;
    end else if (step && col_r == 12'(LINE_LEN - 1) && row_r == 12'(FRAME_ROWS - 1)) begin
      // grant taken only at frame start so frames are whole
      frm_out_r <= grant_p;
      field_r <= ~field_r;
    end else if (step && col_r == 12'h000 && row_r == 12'(ACT_ROWS)) begin
      fe_tgl_r <= ~fe_tgl_r;
      od_tgl_r <= od_tgl_r ^ frm_out_r;
    end
  end

  // port pins, updated once per pixel
  always_ff @(posedge i_pix_clk) begin
    if (prst_r) begin
      pix_on_r <= 1'b0;
      ls_r <= 1'b0;
      fs_r <= 1'b0;
      data_r <= '0;
    end else if (step) begin
      pix_on_r <= frm_out_r && row_act && col_act;
      data_r <= (frm_out_r && row_act && col_act) ? i_pix_data : '0;
      // R06 line form and polarity
      if (pc.ls_form) begin
        ls_r <= ~(frm_out_r && ls_pls);
      end else begin
        ls_r <= (frm_out_r && ls_lvl) ^ pc.ls_pol;
      end
      // R07 field indicator on frame pin
      if (pc.field_en) begin
        fs_r <= field_r;
      // R02 frame form, R05 polarity
      end else if (pc.fs_form) begin
        fs_r <= ~(frm_out_r && fs_pls);
      end else begin
        fs_r <= (frm_out_r && row_act) ^ pc.fs_pol;
      end
    end
  end

  // pixel clock and output enable
  always_ff @(posedge i_pix_clk) begin
    if (prst_r) begin
      pclk_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      // R01 gated clock rests at edge level
      // R04 edge select sets phase
      pclk_r <= (pc.pclk_gate && !pix_on_r) ? pc.pclk_edge : (~ph_r ^ pc.pclk_edge);
      // R08 float releases port
      oe_r <= ~pc.port_float;
    end
  end

  assign o_pix_data = data_r;
  assign o_line_sync = ls_r;
  assign o_frame_sync = fs_r;
  assign o_pclk = pclk_r;
  assign o_port_oe = oe_r;

  // ---------------- checks ----------------
  sequence s_ls_low8;
    (!o_line_sync) [*8];
  endsequence

  sequence s_done_in_readout;
    (state_r == vport_pkg::SNAP_READOUT) && out_done;
  endsequence

  AST_LS_PULSE_LEN: assert property (@(posedge i_pix_clk) disable iff (prst_r) // R03
    (pc.ls_form && $past(pc.ls_form) && $fell(o_line_sync)) |-> s_ls_low8)
    else $error("line sync pulse shorter than four pixel clocks");

  AST_FLOAT_OE: assert property (@(posedge i_pix_clk) disable iff (prst_r) // R08
    pc.port_float |=> !o_port_oe)
    else $error("port driven while float set");

  AST_PCLK_GATED: assert property (@(posedge i_pix_clk) disable iff (prst_r) // R01
    (pc.pclk_gate && !pix_on_r) |=> (o_pclk == $past(pc.pclk_edge)))
    else $error("gated pixel clock toggled without data");

  AST_PCLK_FREE: assert property (@(posedge i_pix_clk) disable iff (prst_r) // R04
    (!pc.pclk_gate && !$past(pc.pclk_gate) && $stable(pc.pclk_edge)) ##1
      $stable(pc.pclk_edge) |->
      (o_pclk != $past(o_pclk)) && (ph_r || (o_pclk == pc.pclk_edge)))
    else $error("free pixel clock out of phase");

  AST_TRIG_IGNORED: assert property (@(posedge i_core_clk) disable iff (i_rst) // R17
    (!trig_en && state_r == vport_pkg::SNAP_IDLE) |=> (state_r == vport_pkg::SNAP_IDLE))
    else $error("sequence started with pin disabled");

  AST_ONE_PER_PULSE: assert property (@(posedge i_core_clk) disable iff (i_rst) // R15
    (s_done_in_readout and !trig_level) |=> (state_r == vport_pkg::SNAP_IDLE))
    else $error("pulse form ran more than one sequence");

  AST_LEVEL_REPEAT: assert property (@(posedge i_core_clk) disable iff (i_rst) // R14
    (s_done_in_readout and (trig_en && trig_level && trig_act)) |=>
      (state_r == vport_pkg::SNAP_EXPOSE))
    else $error("level form did not repeat");

  AST_FRAME_WAIT: assert property (@(posedge i_core_clk) disable iff (i_rst) // R10
    (state_r == vport_pkg::SNAP_EXPOSE && !shutter && frame_end &&
     (frm_cnt_r + 2'b01 != frm_need)) |=> (state_r == vport_pkg::SNAP_EXPOSE))
    else $error("readout began before frame count reached");

  AST_XSYNC_POL: assert property (@(posedge i_core_clk) disable iff (i_rst) // R13
    (state_r == vport_pkg::SNAP_EXPOSE) ##1 $stable(snap_cfg_r) |->
      (o_ext_sync == ~snap_cfg_r[vport_pkg::B_XSYNC_POL]))
    else $error("external sync not at active level while exposing");

endmodule : vport_sync_snap

// ### tb/vport_capture_model.sv
// Purpose: capture-side model that measures video port run lengths
// Assumes: port outputs are looked at on the link clock only while driven
// Notes: a floated port carries no level, so the run in progress is dropped then
`timescale 1ns/1ps
module vport_capture_model (
  input wire logic i_pix_clk,
  input wire logic i_clr,
  input wire logic i_oe,
  input wire logic [3:0] i_sig,
  output logic [3:0][15:0] o_max_hi,
  output logic [3:0][15:0] o_max_lo
);
  logic [3:0] prev_r; // last sampled level per signal
  logic [3:0][15:0] len_r; // length of the run in progress

  // longest completed high and low runs since the last clear
  always_ff @(posedge i_pix_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (i_clr) begin
        o_max_hi[k] <= 16'h0000;
        o_max_lo[k] <= 16'h0000;
        len_r[k] <= 16'h0000;
      end else if (!i_oe) begin
        // released pins: forget the run rather than trust a stale level
        len_r[k] <= 16'h0000;
      end else if (len_r[k] == 16'h0000 || i_sig[k] == prev_r[k]) begin
        len_r[k] <= len_r[k] + 16'h0001;
      end else begin
        if (prev_r[k] && len_r[k] > o_max_hi[k]) begin
          o_max_hi[k] <= len_r[k];
        end
        if (!prev_r[k] && len_r[k] > o_max_lo[k]) begin
          o_max_lo[k] <= len_r[k];
        end
        len_r[k] <= 16'h0001;
      end
      prev_r[k] <= i_sig[k];
    end
  end
endmodule : vport_capture_model

// ### tb/vport_sync_snap_bench.sv
// Purpose: self-checking bench for the video port sync and snapshot control
// Assumes: small geometry, so one frame lasts about 323 core cycles
// Notes: run lengths are link cycles; two link cycles make one pixel clock
`timescale 1ns/1ps
module vport_sync_snap_bench;
  logic i_core_clk = 1'b0;
  logic i_pix_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_snapshot_trig = 1'b1; // idle for falling-edge select
  logic [11:0] i_pix_data = 12'h0a5c; // fixed pixel value
  logic [7:0] o_reg_rdata;
  logic [11:0] o_pix_data;
  logic o_ext_sync;
  logic o_snap_busy;
  logic o_pclk;
  logic o_line_sync;
  logic o_frame_sync;
  logic o_port_oe;
  logic clr = 1'b1; // holds the capture model cleared
  logic [3:0][15:0] max_hi; // index 0 line sync, 1 frame sync, 2 pclk, 3 pixel valid
  logic [3:0][15:0] max_lo;
  int err_total = 0;
  int cmp_count = 0;
  int n;

  // core clock, 50 ns
  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end
  // link clock, 48 ns, offset so edges drift against the core clock
  initial begin
    #7;
    forever #24 i_pix_clk = ~i_pix_clk;
  end

  vport_sync_snap #(.ACT_COLS(8), .ACT_ROWS(4), .H_BLANK(4), .V_BLANK(2)) DUT (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_pix_clk(i_pix_clk),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_snapshot_trig(i_snapshot_trig),
    .o_ext_sync(o_ext_sync), .o_snap_busy(o_snap_busy), .i_pix_data(i_pix_data),
    .o_pix_data(o_pix_data), .o_pclk(o_pclk), .o_line_sync(o_line_sync),
    .o_frame_sync(o_frame_sync), .o_port_oe(o_port_oe));

  vport_capture_model model (.i_pix_clk(i_pix_clk), .i_clr(clr), .i_oe(o_port_oe),
    .i_sig({o_pix_data == 12'h0a5c, o_pclk, o_frame_sync, o_line_sync}),
    .o_max_hi(max_hi), .o_max_lo(max_lo));

  // counts, verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rng(input string nm, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : rng

  // every task leaves just after a rising core edge
  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask : cyc

  // one-cycle write strobe, then a quiet edge so writes never abut
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    cyc(1);
    i_reg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_reg_addr = a;
    cyc(2);
    chk("reg_rdata", {8'h00, exp}, {8'h00, o_reg_rdata});
  endtask : rd

  // bounded wait on busy or on external sync; a timeout ends the run
  task automatic wait_sig(input bit ext, input logic val, input int bound, output int k);
    k = 0;
    while ((ext ? o_ext_sync : o_snap_busy) !== val) begin
      cyc(1);
      k++;
      if (k >= bound) begin
        err_total++;
        $display("MISMATCH wait expected %b seen timeout", val);
        conclude();
      end
    end
  endtask : wait_sig

  // settle for a frame, then gather runs over about three frames
  task automatic meas(input logic [7:0] c7, input logic [7:0] c8);
    clr = 1'b1;
    wr(vport_pkg::OFS_SYNC_CFG, c7);
    wr(vport_pkg::OFS_LEAD_ADJ, c8);
    cyc(400);
    clr = 1'b0;
    cyc(1100);
  endtask : meas

  // one pulsed snapshot; exposure length bounded in core cycles
  task automatic snap(input logic [7:0] cfg, input int lo, input int hi);
    // disarm first: moving the edge select under a held pin reads as an edge
    wr(vport_pkg::OFS_SNAP_CFG, cfg & 8'hfe);
    i_snapshot_trig = ~cfg[1];
    cyc(4);
    wr(vport_pkg::OFS_SNAP_CFG, cfg);
    cyc(4);
    i_snapshot_trig = cfg[1];
    cyc(5);
    i_snapshot_trig = ~cfg[1];
    wait_sig(1'b0, 1'b1, 12, n);
    chk("ext_sync_active", {15'h0000, ~cfg[4]}, {15'h0000, o_ext_sync});
    wait_sig(1'b1, cfg[4], 1100, n);
    rng("expose_cycles", lo, hi, n);
    wait_sig(1'b0, 1'b0, 1400, n);
    chk("ext_sync_idle", {15'h0000, cfg[4]}, {15'h0000, o_ext_sync});
  endtask : snap

  initial begin
    cyc(8);
    i_rst = 1'b0;
    cyc(20);
    rd(vport_pkg::OFS_SYNC_CFG, vport_pkg::RST_SYNC_CFG);
    rd(vport_pkg::OFS_LEAD_ADJ, vport_pkg::RST_LEAD_ADJ);
    rd(vport_pkg::OFS_SNAP_CFG, vport_pkg::RST_SNAP_CFG);
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h00);
    wr(vport_pkg::OFS_LEAD_ADJ, 8'ha5);
    rd(vport_pkg::OFS_LEAD_ADJ, 8'ha5);
    wr(vport_pkg::OFS_SNAP_CFG, 8'h5a);
    rd(vport_pkg::OFS_SNAP_CFG, 8'h5a);
    wr(vport_pkg::OFS_SNAP_CFG, 8'h00);
    chk("port_oe", 16'h0001, {15'h0000, o_port_oe});
    wr(vport_pkg::OFS_SYNC_CFG, 8'h01);
    cyc(20);
    chk("port_oe", 16'h0000, {15'h0000, o_port_oe});
    $display("test registers and float done");
    // video mode runs, in link cycles
    meas(8'h00, 8'h00);
    chk("ls_hi", 16'h0010, max_hi[0]);
    chk("fs_hi", 16'h00e0, max_hi[1]);
    chk("pclk_hi", 16'h0001, max_hi[2]);
    chk("pclk_lo", 16'h0001, max_lo[2]);
    chk("data_hi", 16'h0010, max_hi[3]);
    chk("data_lo", 16'h0098, max_lo[3]);
    meas(8'h00, 8'hf0);
    chk("ls_hi", 16'h002e, max_hi[0]);
    meas(8'h0c, 8'h00);
    chk("ls_lo", 16'h0010, max_lo[0]);
    chk("fs_lo", 16'h00e0, max_lo[1]);
    meas(8'h60, 8'h00);
    chk("ls_lo", 16'h0008, max_lo[0]);
    chk("fs_lo", 16'h0008, max_lo[1]);
    meas(8'h02, 8'h00);
    chk("fs_hi", 16'h0150, max_hi[1]);
    chk("fs_lo", 16'h0150, max_lo[1]);
    meas(8'h80, 8'h00);
    chk("pclk_hi", 16'h0001, max_hi[2]);
    rng("pclk_lo", 3, 60000, int'(max_lo[2]));
    meas(8'h90, 8'h00);
    chk("pclk_lo", 16'h0001, max_lo[2]);
    rng("pclk_hi", 3, 60000, int'(max_hi[2]));
    $display("test port timing done");
    // frame counts always non-zero here
    snap(8'h41, 0, 330);
    cyc(700);
    chk("busy_single", 16'h0000, {15'h0000, o_snap_busy});
    snap(8'h81, 318, 652);
    snap(8'hc1, 636, 975);
    snap(8'he1, 0, 330);
    snap(8'h51, 0, 330);
    snap(8'h43, 0, 330);
    i_snapshot_trig = 1'b0;
    wr(vport_pkg::OFS_SNAP_CFG, 8'h42);
    i_snapshot_trig = 1'b1;
    cyc(20);
    chk("busy_disabled", 16'h0000, {15'h0000, o_snap_busy});
    $display("test snapshot pulse done");
    i_snapshot_trig = 1'b0;
    wr(vport_pkg::OFS_SNAP_CFG, 8'h47);
    i_snapshot_trig = 1'b1;
    wait_sig(1'b0, 1'b1, 12, n);
    n = 0;
    for (int k = 0; k < 1500; k++) begin
      cyc(1);
      n += (o_snap_busy !== 1'b1) ? 1 : 0;
    end
    rng("busy_gaps", 0, 0, n);
    i_snapshot_trig = 1'b0;
    wait_sig(1'b0, 1'b0, 1400, n);
    $display("test snapshot level done");
    conclude();
  end
endmodule : vport_sync_snap_bench
